// >>> hdl/acp_config_port.sv
// serial configuration port of a dual-core converter: instruction
// decoder, shift engine and register bank.
// assumes sclk, select_n and sdio_in are synchronous to clk and sclk is
// far slower than clk, so every sclk edge is seen as a level change.
//
// Function
// - 3-wire default; setup bit 7 adds output
// - 4-wire mode drives output line while unselected
// - first sclk rise after select starts instruction
// - setup bit 6 selects lsb-first serial order
// - address increments msb-first, decrements lsb-first
// - instruction: read flag, count, 13-bit address
// - count 00..10 gives 1..3, 11 streams
// - short transfers resume after select pauses
// - streaming: late select rise aborts transfer
// - soft reset bit restores defaults, power exempt
// - burst last address ends streaming transfer
// - read-only die identifier and revision registers
// - core index, zero selects none, reads AD
// - per-core coarse and fine offset trims
// - trims start at calibration values, read-modify-write
// - coarse gain four independently weighted bits
// - medium and fine gain 8-bit trims
// - power field per core, pin when zero
// - skew trim register, resets to zero
// - write 0 then 1 to slip bit pulses
`timescale 1ns/1ps
`default_nettype none
`include "acp_map.svh"

module acp_config_port #(
	parameter int NCORE = 2,
	parameter logic [7:0] DIE_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] DIE_REV = 8'h01, // arbitrary value
	parameter logic [7:0] CAL_OFS = 8'h80,
	parameter logic [3:0] CAL_GAIN_COARSE = 4'h0,
	parameter logic [7:0] CAL_GAIN = 8'h80
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic select_n,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n,
	output logic serial_out_line,
	output logic serial_out_oe_n,
	input wire logic [1:0] power_mode_pin,
	output logic four_wire_mode,
	output logic [NCORE-1:0][7:0] offset_coarse,
	output logic [NCORE-1:0][7:0] offset_fine,
	output logic [NCORE-1:0][3:0] gain_coarse,
	output logic [NCORE-1:0][7:0] gain_medium,
	output logic [NCORE-1:0][7:0] gain_fine,
	output logic [NCORE-1:0][1:0] power_state,
	output logic [7:0] skew_trim,
	output logic phase_slip_pulse
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7-i];
		end
		return r;
	endfunction

	function automatic logic [15:0] rev16(input logic [15:0] v);
		return {rev8(v[7:0]), rev8(v[15:8])};
	endfunction

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------

	logic [7:0] port_q;
	logic [7:0] burst_q;
	logic [7:0] core_sel_q;
	logic [7:0] skew_q;
	logic [7:0] slip_q;
	logic slip_armed_q;
	logic slip_pulse_q;
	logic [7:0] ofs_c_q [NCORE];
	logic [7:0] ofs_f_q [NCORE];
	logic [3:0] gain_c_q [NCORE];
	logic [7:0] gain_m_q [NCORE];
	logic [7:0] gain_f_q [NCORE];
	logic [2:0] pwr_q [NCORE];

	// write strobe from the shift engine
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic soft_rst;

	// ------------------------------------------------------------
	// shift engine state
	// ------------------------------------------------------------

	acp_pkg::acp_state_e state_q;
	logic [3:0] bit_q;
	logic [14:0] ins_q;
	logic [6:0] din_q;
	logic [7:0] dout_q;
	logic [12:0] addr_q;
	logic rw_q;
	logic stream_q;
	logic [1:0] left_q;
	logic any_data_q;
	logic sclk_q;

	logic lsb_first;
	logic sclk_rise;
	logic sclk_fall;
	logic [15:0] ins_word;
	logic [7:0] din_word;
	logic [12:0] step_addr;
	logic [12:0] rd_addr;
	logic [7:0] rd_data;
	logic [7:0] rd_load;
	logic last_byte;
	logic rd_next;

	assign lsb_first = port_q[`ACP_B_LSB_FIRST];
	assign four_wire_mode = port_q[`ACP_B_FOUR_WIRE];

	// edges only count while selected
	assign sclk_rise = sclk & ~sclk_q & ~select_n;
	assign sclk_fall = ~sclk & sclk_q & ~select_n;

	// whole instruction is reversed in lsb-first order
	assign ins_word = lsb_first ? rev16({ins_q, sdio_in}) :
		{ins_q, sdio_in};
	assign din_word = lsb_first ? rev8({din_q, sdio_in}) :
		{din_q, sdio_in};
	assign step_addr = lsb_first ? addr_q - 13'h1 : addr_q + 13'h1;
	assign rd_addr = (state_q == acp_pkg::ACP_ST_INSTR) ?
		ins_word[`ACP_I_ADDR_HI:0] : step_addr;
	assign rd_load = lsb_first ? rev8(rd_data) : rd_data;

	// streaming ends at the burst address, short ones by count
	assign last_byte = stream_q ?
		(addr_q == {5'h00, burst_q}) : (left_q == 2'h0);
	// this rise ends a byte that a read byte follows
	assign rd_next = (state_q == acp_pkg::ACP_ST_INSTR &&
		bit_q == `ACP_I_LAST_BIT) ? ins_word[`ACP_I_RW] :
		(state_q == acp_pkg::ACP_ST_DATA && bit_q == `ACP_D_LAST_BIT &&
		rw_q && !last_byte);

	// sclk history for edge detection
	always_ff @(posedge clk) begin
		if (rst) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk;
		end
	end

	// instruction and data sequencing
	always_ff @(posedge clk) begin
		if (rst || soft_rst) begin
			state_q <= acp_pkg::ACP_ST_INSTR;
			bit_q <= 4'h0;
			ins_q <= '0;
			din_q <= '0;
			addr_q <= '0;
			rw_q <= 1'b0;
			stream_q <= 1'b0;
			left_q <= 2'h0;
			any_data_q <= 1'b0;
		end else if (select_n) begin
			// pauses keep state except after the last byte or late in a streaming transfer
			if (state_q == acp_pkg::ACP_ST_DONE ||
				(state_q == acp_pkg::ACP_ST_DATA && stream_q &&
				(any_data_q || bit_q != 4'h0))) begin
				state_q <= acp_pkg::ACP_ST_INSTR;
				bit_q <= 4'h0;
			end
		end else if (sclk_rise) begin
			case (state_q)
				acp_pkg::ACP_ST_INSTR: begin
					// raw arrival order; reversal only on decode
					ins_q <= {ins_q[13:0], sdio_in};
					if (bit_q == `ACP_I_LAST_BIT) begin
						rw_q <= ins_word[`ACP_I_RW];
						stream_q <= ins_word[`ACP_I_CNT_HI:`ACP_I_CNT_LO] ==
							`ACP_CNT_STREAM;
						left_q <= ins_word[`ACP_I_CNT_HI:`ACP_I_CNT_LO];
						addr_q <= ins_word[`ACP_I_ADDR_HI:0];
						any_data_q <= 1'b0;
						bit_q <= 4'h0;
						state_q <= acp_pkg::ACP_ST_DATA;
					end else begin
						bit_q <= bit_q + 4'h1;
					end
				end
				acp_pkg::ACP_ST_DATA: begin
					din_q <= {din_q[5:0], sdio_in};
					if (bit_q == `ACP_D_LAST_BIT) begin
						bit_q <= 4'h0;
						any_data_q <= 1'b1;
						if (last_byte) begin
							state_q <= acp_pkg::ACP_ST_DONE;
						end else begin
							addr_q <= step_addr;
							left_q <= left_q - 2'h1;
						end
					end else begin
						bit_q <= bit_q + 4'h1;
					end
				end
				default: bit_q <= 4'h0;
			endcase
		end
	end

	// write strobe raised on the last bit of a write data byte
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_en <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
		end else begin
			wr_en <= sclk_rise && state_q == acp_pkg::ACP_ST_DATA &&
				!rw_q && bit_q == `ACP_D_LAST_BIT && !select_n &&
				addr_q[`ACP_I_ADDR_HI:8] == 5'h00;
			wr_addr <= addr_q[`ACP_I_BYTE_HI:0];
			wr_data <= din_word;
		end
	end

	// read shifter: loaded on a rising edge, advanced on falling edges
	always_ff @(posedge clk) begin
		if (rst) begin
			dout_q <= '0;
		end else if (sclk_rise && rd_next) begin
			dout_q <= rd_load;
		end else if (sclk_fall && state_q == acp_pkg::ACP_ST_DATA &&
			rw_q && bit_q != 4'h0) begin
			dout_q <= {dout_q[6:0], 1'b0};
		end
	end


	// ------------------------------------------------------------
	// pins
	// ------------------------------------------------------------

	// shared line driven only during read data in 3-wire mode
	assign sdio_out = dout_q[7];
	assign sdio_oe_n = ~(state_q == acp_pkg::ACP_ST_DATA && rw_q &&
		!select_n && !four_wire_mode);
	// dedicated output stays on whenever 4-wire is set, even unselected
	assign serial_out_line = dout_q[7];
	assign serial_out_oe_n = ~four_wire_mode;

	// ------------------------------------------------------------
	// register bank
	// ------------------------------------------------------------

	assign soft_rst = wr_en && wr_addr == `ACP_A_PORT &&
		wr_data[`ACP_B_SOFT_RST];

	// global registers; soft reset bit itself is never stored
	always_ff @(posedge clk) begin
		if (rst || soft_rst) begin
			port_q <= `ACP_R_PORT;
			burst_q <= `ACP_R_BURST;
			core_sel_q <= `ACP_R_CORE_SEL;
			skew_q <= `ACP_R_SKEW;
			slip_q <= `ACP_R_SLIP;
		end else if (wr_en) begin
			case (wr_addr)
				`ACP_A_PORT: port_q <= wr_data;
				`ACP_A_BURST: burst_q <= wr_data;
				`ACP_A_CORE_SEL: core_sel_q <= wr_data;
				`ACP_A_SKEW: skew_q <= wr_data;
				`ACP_A_SLIP: slip_q <= wr_data;
				default: ;
			endcase
		end
	end

	// phase slip needs a 0 write before the 1 write
	always_ff @(posedge clk) begin
		if (rst || soft_rst) begin
			slip_armed_q <= 1'b0;
			slip_pulse_q <= 1'b0;
		end else begin
			slip_pulse_q <= wr_en && wr_addr == `ACP_A_SLIP &&
				wr_data[0] && slip_armed_q;
			if (wr_en && wr_addr == `ACP_A_SLIP) begin
				slip_armed_q <= ~wr_data[0];
			end
		end
	end

	assign phase_slip_pulse = slip_pulse_q;
	assign skew_trim = skew_q;

	// per-core trims and power field, written through the core index
	for (genvar k = 0; k < NCORE; k++) begin : g_core
		logic hit;
		assign hit = wr_en && core_sel_q[k];

		// trims restart at calibration values
		always_ff @(posedge clk) begin
			if (rst || soft_rst) begin
				ofs_c_q[k] <= CAL_OFS;
				ofs_f_q[k] <= CAL_OFS;
				gain_c_q[k] <= CAL_GAIN_COARSE;
				gain_m_q[k] <= CAL_GAIN;
				gain_f_q[k] <= CAL_GAIN;
			end else if (hit) begin
				case (wr_addr)
					`ACP_A_OFS_COARSE: ofs_c_q[k] <= wr_data;
					`ACP_A_OFS_FINE: ofs_f_q[k] <= wr_data;
					`ACP_A_GAIN_COARSE: gain_c_q[k] <= wr_data[3:0];
					`ACP_A_GAIN_MEDIUM: gain_m_q[k] <= wr_data;
					`ACP_A_GAIN_FINE: gain_f_q[k] <= wr_data;
					default: ;
				endcase
			end
		end

		// power field ignores soft reset
		always_ff @(posedge clk) begin
			if (rst) begin
				pwr_q[k] <= `ACP_R_PWR;
			end else if (hit && wr_addr == `ACP_A_PWR) begin
				pwr_q[k] <= wr_data[2:0];
			end
		end

		// resolved state; reserved codes fall back to the pin
		always_comb begin
			case (pwr_q[k])
				`ACP_PD_NORMAL: power_state[k] = acp_pkg::ACP_PWR_NORMAL;
				`ACP_PD_NAP: power_state[k] = acp_pkg::ACP_PWR_NAP;
				`ACP_PD_SLEEP: power_state[k] = acp_pkg::ACP_PWR_SLEEP;
				default: power_state[k] = power_mode_pin;
			endcase
		end

		assign offset_coarse[k] = ofs_c_q[k];
		assign offset_fine[k] = ofs_f_q[k];
		assign gain_coarse[k] = gain_c_q[k];
		assign gain_medium[k] = gain_m_q[k];
		assign gain_fine[k] = gain_f_q[k];
	end

	// read mux; indexed reads use the lowest selected core
	always_comb begin
		logic found;
		logic [7:0] idx_val;
		logic [7:0] a;
		found = 1'b0;
		idx_val = `ACP_NO_CORE_CODE;
		a = rd_addr[`ACP_I_BYTE_HI:0];
		for (int k = 0; k < NCORE; k++) begin
			if (!found && core_sel_q[k]) begin
				found = 1'b1;
				case (a)
					`ACP_A_OFS_COARSE: idx_val = ofs_c_q[k];
					`ACP_A_OFS_FINE: idx_val = ofs_f_q[k];
					`ACP_A_GAIN_COARSE: idx_val = {4'h0, gain_c_q[k]};
					`ACP_A_GAIN_MEDIUM: idx_val = gain_m_q[k];
					`ACP_A_GAIN_FINE: idx_val = gain_f_q[k];
					default: idx_val = {5'h00, pwr_q[k]};
				endcase
			end
		end
		rd_data = `ACP_RD_ZERO;
		if (rd_addr[`ACP_I_ADDR_HI:8] == 5'h00) begin
			case (a)
				`ACP_A_PORT: rd_data = port_q;
				`ACP_A_BURST: rd_data = burst_q;
				`ACP_A_DIE_ID: rd_data = DIE_ID;
				`ACP_A_DIE_REV: rd_data = DIE_REV;
				`ACP_A_CORE_SEL: rd_data = core_sel_q;
				`ACP_A_OFS_COARSE, `ACP_A_OFS_FINE, `ACP_A_GAIN_COARSE,
				`ACP_A_GAIN_MEDIUM, `ACP_A_GAIN_FINE,
				`ACP_A_PWR: rd_data = idx_val;
				`ACP_A_SKEW: rd_data = skew_q;
				`ACP_A_SLIP: rd_data = slip_q;
				default: rd_data = `ACP_RD_ZERO;
			endcase
		end
	end

endmodule

`default_nettype wire

// >>> hdl/acp_map.svh
// register offsets, field positions, reset values and codes of the
// converter configuration port; definitions only, included by bare name
`ifndef ACP_MAP_SVH
`define ACP_MAP_SVH

// register offsets (low byte of the 13-bit address)
`define ACP_A_PORT 8'h00
`define ACP_A_BURST 8'h02
`define ACP_A_DIE_ID 8'h08
`define ACP_A_DIE_REV 8'h09
`define ACP_A_CORE_SEL 8'h10
`define ACP_A_OFS_COARSE 8'h20
`define ACP_A_OFS_FINE 8'h21
`define ACP_A_GAIN_COARSE 8'h22
`define ACP_A_GAIN_MEDIUM 8'h23
`define ACP_A_GAIN_FINE 8'h24
`define ACP_A_PWR 8'h25
`define ACP_A_SKEW 8'h70
`define ACP_A_SLIP 8'h71

// port_setup fields
`define ACP_B_FOUR_WIRE 7
`define ACP_B_LSB_FIRST 6
`define ACP_B_SOFT_RST 5

// instruction fields
`define ACP_I_RW 15
`define ACP_I_CNT_HI 14
`define ACP_I_CNT_LO 13
`define ACP_I_ADDR_HI 12
`define ACP_I_BYTE_HI 7
`define ACP_I_LAST_BIT 4'hF
`define ACP_D_LAST_BIT 4'h7
`define ACP_CNT_STREAM 2'h3

// reset values and codes
`define ACP_R_PORT 8'h00
`define ACP_R_CORE_SEL 8'h00
`define ACP_R_SKEW 8'h00
`define ACP_R_SLIP 8'h00
`define ACP_R_BURST 8'hFF
`define ACP_R_PWR 3'h0
`define ACP_NO_CORE_CODE 8'hAD
`define ACP_RD_ZERO 8'h00

// power-down field codes
`define ACP_PD_PIN 3'h0
`define ACP_PD_NORMAL 3'h1
`define ACP_PD_NAP 3'h2
`define ACP_PD_SLEEP 3'h4

`endif

// >>> hdl/acp_pkg.sv
// types of the converter configuration port
// used by the port module
package acp_pkg;

	// transfer sequencing
	typedef enum logic [1:0] {
		ACP_ST_INSTR = 2'b00,
		ACP_ST_DATA = 2'b01,
		ACP_ST_DONE = 2'b10
	} acp_state_e;

	// resolved power state of a core, also the tri-level pin code
	typedef enum logic [1:0] {
		ACP_PWR_NORMAL = 2'b00,
		ACP_PWR_NAP = 2'b01,
		ACP_PWR_SLEEP = 2'b10
	} acp_pwr_e;

endpackage

// >>> verif/acp_config_port_sva.sv
// timing checks on the configuration port, bound to every port instance
// assumes sclk phases last several clk, as the serial master keeps them
`timescale 1ns/1ps
`default_nettype none
module acp_config_port_sva #(
	parameter int NCORE = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic select_n,
	input wire logic sdio_oe_n,
	input wire logic serial_out_oe_n,
	input wire logic four_wire_mode,
	input wire logic [NCORE-1:0][7:0] offset_coarse,
	input wire logic [7:0] skew_trim,
	input wire logic phase_slip_pulse
);
	// --------------------------------
	// port relations
	// --------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_oe_needs_select: assert property (
		!sdio_oe_n |-> !select_n) else $error("line driven unselected");
	a_oe_three_wire: assert property (
		!sdio_oe_n |-> !four_wire_mode) else $error("line driven in 4-wire");
	a_out_oe_mode: assert property (
		four_wire_mode != serial_out_oe_n) else $error("out enable wrong");
	// the line opens at the sixteenth rise, while sclk is still high
	a_oe_opens_high: assert property (
		$fell(sdio_oe_n) |-> sclk) else $error("line opened off a rise");
	a_skew_at_byte: assert property (
		$changed(skew_trim) |-> sclk || $past(sclk))
		else $error("skew changed off a byte end");
	a_trim_at_byte: assert property (
		$changed(offset_coarse) |-> sclk || $past(sclk))
		else $error("offset changed off a byte end");
	a_mode_at_byte: assert property (
		$changed(four_wire_mode) |-> sclk || $past(sclk))
		else $error("mode changed off a byte end");
	a_slip_one_cycle: assert property (
		phase_slip_pulse |=> !phase_slip_pulse) else $error("slip too long");
	a_slip_after_rise: assert property (
		phase_slip_pulse |-> $past(sclk, 2) && !$past(sclk, 3))
		else $error("slip not after a byte");
endmodule
bind acp_config_port acp_config_port_sva #(.NCORE(NCORE)) i_sva (
	.clk(clk),
	.rst(rst),
	.sclk(sclk),
	.select_n(select_n),
	.sdio_oe_n(sdio_oe_n),
	.serial_out_oe_n(serial_out_oe_n),
	.four_wire_mode(four_wire_mode),
	.offset_coarse(offset_coarse),
	.skew_trim(skew_trim),
	.phase_slip_pulse(phase_slip_pulse)
);
`default_nettype wire

// >>> verif/acp_master.sv
// behavioural serial master for the configuration port
// assumes one device on the bus and a clk far faster than sclk
`timescale 1ns/1ps
`default_nettype none
module acp_master (
	input wire logic clk,
	output logic sclk,
	output logic select_n,
	output logic sdio_in,
	input wire logic sdio_out,
	input wire logic sdio_oe_n,
	input wire logic serial_out_line
);
	logic drv_q = 1'b1;
	logic bit_q = 1'b0;
	logic junk_q = 1'b0;
	logic lsb = 1'b0;
	logic four = 1'b0;
	initial begin
		sclk = 1'b0;
		select_n = 1'b1;
	end
	// --------------------------------
	// shared line
	// --------------------------------
	// released line toggles so a stale bit can never pass as data
	always @(posedge clk) junk_q <= ~junk_q;
	assign sdio_in = !sdio_oe_n ? sdio_out : (drv_q ? bit_q : junk_q);
	// at least four clk per phase keeps sclk slow against the sample rate
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// sclk is already low whenever select moves
	task sel(input logic v);
		@(posedge clk);
		select_n <= v;
		if (v) drv_q <= 1'b1;
		tick(3);
	endtask
	task xbyte(input logic [7:0] tx, input logic d, output logic [7:0] rx);
		int k;
		for (int i = 0; i < 8; i++) begin
			k = lsb ? i : 7 - i;
			@(posedge clk);
			bit_q <= tx[k];
			drv_q <= d;
			tick(3);
			@(posedge clk);
			sclk <= 1'b1;
			rx[k] = four ? serial_out_line : sdio_in;
			tick(3);
			@(posedge clk);
			sclk <= 1'b0;
		end
	endtask
	task instr(input logic rw, input logic [1:0] cnt, input logic [12:0] a);
		logic [15:0] w;
		logic [7:0] r;
		w = {rw, cnt, a};
		if (lsb) begin
			xbyte(w[7:0], 1'b1, r);
			xbyte(w[15:8], 1'b1, r);
		end else begin
			xbyte(w[15:8], 1'b1, r);
			xbyte(w[7:0], 1'b1, r);
		end
	endtask
endmodule
`default_nettype wire

// >>> verif/test_adc_spi_config_port.sv
// self-checking bench of the configuration port with a serial master
// assumes the port and the master model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_adc_spi_config_port;
	localparam logic [7:0] ID = 8'h3C; // arbitrary value
	localparam logic [7:0] REV = 8'h07; // arbitrary value
	localparam logic [7:0] MID = 8'h80;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] power_mode_pin = 2'h1;
	wire logic sclk, select_n, sdio_in, sdio_out, sdio_oe_n;
	wire logic serial_out_line, serial_out_oe_n, four_wire_mode;
	wire logic phase_slip_pulse;
	wire logic [7:0] skew_trim;
	wire logic [1:0][7:0] ofs_c, ofs_f, gain_m, gain_f;
	wire logic [1:0][3:0] gain_c;
	wire logic [1:0][1:0] pwr;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	int pulses = 0;
	logic [2:0] code [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
	logic [1:0] pexp [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
	acp_config_port #(.DIE_ID(ID), .DIE_REV(REV)) i_dut (
		.clk(clk), .rst(rst), .sclk(sclk), .select_n(select_n),
		.sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
		.serial_out_line(serial_out_line),
		.serial_out_oe_n(serial_out_oe_n),
		.power_mode_pin(power_mode_pin), .four_wire_mode(four_wire_mode),
		.offset_coarse(ofs_c), .offset_fine(ofs_f), .gain_coarse(gain_c),
		.gain_medium(gain_m), .gain_fine(gain_f), .power_state(pwr),
		.skew_trim(skew_trim), .phase_slip_pulse(phase_slip_pulse));
	acp_master i_master (
		.clk(clk), .sclk(sclk), .select_n(select_n), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
		.serial_out_line(serial_out_line));
	// --------------------------------
	// clock, watchdog and helpers
	// --------------------------------
	always #5 clk = ~clk;
	// whole run needs under 20000 cycles
	always @(posedge clk) begin
		cycles++;
		if (phase_slip_pulse === 1'b1) pulses++;
		if (cycles == 40000) begin
			fails++;
			give_verdict();
		end
	end
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task wr(input logic [12:0] a, input logic [7:0] v);
		logic [7:0] r;
		i_master.sel(1'b0);
		i_master.instr(1'b0, 2'h0, a);
		i_master.xbyte(v, 1'b1, r);
		i_master.sel(1'b1);
	endtask
	// only one device on the bus, so reads never collide
	task rd(input logic [12:0] a, output logic [7:0] v);
		i_master.sel(1'b0);
		i_master.instr(1'b1, 2'h0, a);
		i_master.xbyte(8'h00, 1'b0, v);
		i_master.sel(1'b1);
	endtask
	// --------------------------------
	// scenarios
	// --------------------------------
	task t_reset;
		logic [7:0] v;
		rd(13'h08, v); chk("id", ID, v);
		rd(13'h09, v); chk("rev", REV, v);
		rd(13'h10, v); chk("core select", 8'h00, v);
		rd(13'h20, v); chk("no core", 8'hAD, v);
		chk("skew", 8'h00, skew_trim);
		chk("four wire", 8'h00, {7'h0, four_wire_mode});
		$display("test reset done");
	endtask
	task t_trims;
		logic [7:0] v, w;
		wr(13'h10, 8'h01);
		rd(13'h20, v); chk("offset cal", MID, v);
		wr(13'h20, v + 8'h01); chk("offset c0", 8'h81, ofs_c[0]);
		chk("offset c1", MID, ofs_c[1]);
		i_master.sel(1'b0);
		i_master.instr(1'b0, 2'h2, 13'h22);
		i_master.xbyte(8'h05, 1'b1, v);
		i_master.sel(1'b1);
		i_master.sel(1'b0);
		i_master.xbyte(8'h44, 1'b1, v);
		i_master.xbyte(8'h55, 1'b1, v);
		i_master.sel(1'b1);
		chk("gain coarse", 8'h05, {4'h0, gain_c[0]});
		chk("gain medium", 8'h44, gain_m[0]);
		chk("gain fine", 8'h55, gain_f[0]);
		chk("gain medium c1", MID, gain_m[1]);
		i_master.sel(1'b0);
		i_master.instr(1'b1, 2'h1, 13'h23);
		i_master.xbyte(8'h00, 1'b0, v);
		i_master.xbyte(8'h00, 1'b0, w);
		i_master.sel(1'b1);
		chk("read medium", 8'h44, v);
		chk("read fine", 8'h55, w);
		$display("test trims done");
	endtask
	task t_stream;
		logic [7:0] v;
		i_master.sel(1'b0);
		i_master.instr(1'b0, 2'h3, 13'h20);
		i_master.xbyte(8'h21, 1'b1, v);
		i_master.sel(1'b1);
		// after the abort a fresh instruction must be taken
		i_master.sel(1'b0);
		i_master.instr(1'b0, 2'h0, 13'h70);
		i_master.xbyte(8'h11, 1'b1, v);
		i_master.sel(1'b1);
		chk("stream first", 8'h21, ofs_c[0]);
		chk("stream aborted", MID, ofs_f[0]);
		chk("after abort", 8'h11, skew_trim);
		// streaming stops at the burst last address
		wr(13'h02, 8'h21);
		i_master.sel(1'b0);
		i_master.instr(1'b0, 2'h3, 13'h20);
		i_master.xbyte(8'h30, 1'b1, v);
		i_master.xbyte(8'h31, 1'b1, v);
		i_master.xbyte(8'h0F, 1'b1, v);
		i_master.sel(1'b1);
		chk("burst first", 8'h30, ofs_c[0]);
		chk("burst last", 8'h31, ofs_f[0]);
		chk("burst end", 8'h05, {4'h0, gain_c[0]});
		$display("test stream done");
	endtask
	task t_power;
		for (int i = 0; i < 4; i++) begin
			wr(13'h25, {5'h0, code[i]});
			chk("power c0", {6'h0, pexp[i]}, {6'h0, pwr[0]});
		end
		chk("power c1", 8'h01, {6'h0, pwr[1]});
		// field 000 hands both cores to the pin
		@(posedge clk);
		power_mode_pin <= 2'h2;
		@(posedge clk);
		@(posedge clk);
		chk("pin c0", 8'h02, {6'h0, pwr[0]});
		chk("pin c1", 8'h02, {6'h0, pwr[1]});
		$display("test power done");
	endtask
	task t_lsb;
		logic [7:0] v;
		wr(13'h00, 8'h5A);
		i_master.lsb = 1'b1;
		i_master.sel(1'b0);
		i_master.instr(1'b0, 2'h1, 13'h71);
		i_master.xbyte(8'h00, 1'b1, v);
		i_master.xbyte(8'hC1, 1'b1, v);
		i_master.sel(1'b1);
		chk("skew lsb", 8'hC1, skew_trim);
		wr(13'h71, 8'h01); chk("slip", 8'h01, 8'(pulses));
		wr(13'h71, 8'h01); chk("no slip", 8'h01, 8'(pulses));
		wr(13'h25, 8'h04);
		wr(13'h00, 8'h3C);
		i_master.lsb = 1'b0;
		chk("soft skew", 8'h00, skew_trim);
		chk("soft offset", MID, ofs_c[0]);
		chk("soft power", 8'h02, {6'h0, pwr[0]});
		rd(13'h10, v); chk("soft select", 8'h00, v);
		$display("test lsb done");
	endtask
	task t_four;
		logic [7:0] v;
		wr(13'h00, 8'h99);
		chk("four on", 8'h01, {7'h0, four_wire_mode});
		chk("out enable", 8'h00, {7'h0, serial_out_oe_n});
		i_master.four = 1'b1;
		rd(13'h09, v); chk("rev 4-wire", REV, v);
		wr(13'h00, 8'h18);
		i_master.four = 1'b0;
		chk("four off", 8'h00, {7'h0, four_wire_mode});
		chk("out off", 8'h01, {7'h0, serial_out_oe_n});
		$display("test four wire done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_trims();
		t_stream();
		t_power();
		t_lsb();
		t_four();
		give_verdict();
	end
endmodule
`default_nettype wire
